//--- logic/pscr_pkg.sv
// Package of offsets, field positions and reset values for the PLL pin/config register bank
package pscr_pkg;
  // Register indices on the write/readback port
  localparam logic [4:0] ADDR_LOCK_PIN  = 5'h0C;
  localparam logic [4:0] ADDR_READBACK  = 5'h0D;
  localparam logic [4:0] ADDR_GPO_B     = 5'h0E;
  localparam logic [4:0] ADDR_FIXED     = 5'h10;
  localparam logic [4:0] ADDR_FILTER    = 5'h18;
  localparam logic [4:0] ADDR_REF_PUMP  = 5'h1A;
  localparam logic [4:0] ADDR_PROTECT   = 5'h1F;
  localparam logic [4:0] ADDR_LAST_PROT = 5'h1E;

  // Field positions (low bit of each field)
  localparam int LOCK_SRC_LSB   = 27;
  localparam int LOCK_TYPE_LSB  = 24;
  localparam int HOLD_SYNC_BIT  = 23;
  localparam int RB_TYPE_LSB    = 24;
  localparam int GPO_A_LSB      = 16;
  localparam int GPO_B_LSB      = 24;
  localparam int CAP_C4_LSB     = 28;
  localparam int CAP_C3_LSB     = 24;
  localparam int RES_R4_LSB     = 20;
  localparam int RES_R3_LSB     = 16;
  localparam int DOUBLER_BIT    = 29;
  localparam int PUMP_LSB       = 26;
  localparam int DLD_CNT_LSB    = 6;
  localparam int PROTECT_BIT    = 5;

  // Lock pin source codes
  localparam logic [4:0] SRC_LOW    = 5'h00;
  localparam logic [4:0] SRC_DLD    = 5'h02;
  localparam logic [4:0] SRC_N      = 5'h0D;
  localparam logic [4:0] SRC_N_HALF = 5'h0E;
  localparam logic [4:0] SRC_R      = 5'h11;
  localparam logic [4:0] SRC_R_HALF = 5'h12;

  // Pin drive type codes
  localparam logic [2:0] DRV_PUSH_PULL = 3'h3;
  localparam logic [2:0] DRV_INVERTED  = 3'h4;
  localparam logic [2:0] DRV_OPEN_SRC  = 3'h5;
  localparam logic [2:0] DRV_OPEN_DRN  = 3'h6;

  // General output state codes
  localparam logic [2:0] GPO_PULL_DOWN = 3'h2;
  localparam logic [2:0] GPO_LOW       = 3'h3;
  localparam logic [2:0] GPO_HIGH      = 3'h4;

  // Reset values of the stored words, address bits included
  localparam logic [31:0] RST_LOCK_PIN = 32'h1300000C;
  localparam logic [31:0] RST_READBACK = 32'h0303000D;
  localparam logic [31:0] RST_GPO_B    = 32'h0300000E;
  localparam logic [31:0] RST_FIXED    = 32'h00000010; // Arbitrary fixed pattern
  localparam logic [31:0] RST_FILTER   = 32'h00000018;
  localparam logic [31:0] RST_REF_PUMP = 32'h0000005A;
  localparam logic        RST_PROTECT  = 1'b0;
endpackage

//--- logic/pscr_regs.sv
// PLL status pin, general output and loop configuration register bank
`timescale 1ns/1ps
// Summary of operation
// - Five-bit source select picks low, lock, N, N/2, R or R/2 for lock pin.
// - Drive type 3 drives source true; type 4 drives it inverted.
// - Lock pin drive type: push-pull, inverted, open source, open drain; 0-2 reserved.
// - Hold-sync bit keeps sync request asserted until digital lock asserts.
// - Readback pin drive type uses the same four codes; 0-2 reserved.
// - General output A: weak pull-down, low or high from its three-bit field.
// - General output B: weak pull-down, low or high from its own field.
// - Four-bit field selects filter capacitor C4; codes 14 and 15 reserved.
// - Four-bit field selects filter capacitor C3; codes 14 and 15 reserved.
// - Three-bit field selects filter resistor R4; codes 5 to 7 reserved.
// - Three-bit field selects filter resistor R3; codes 5 to 7 reserved.
// - Doubler bit presents twice the reference frequency to the detector.
// - Two-bit field sets charge pump current 100, 400, 1600 or 3200 uA.
// - Lock asserts after in-window comparisons reach the fourteen-bit count.
// - While sync request stands, participating clock outputs are forced low.
// - While write protect is set, writes to registers 0 to 30 are ignored.
module pscr_regs #(
  parameter int CNT_W = 14
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [4:0]  rd_addr,
  output logic      [31:0] rd_data,
  input  wire logic        readback_bit,
  input  wire logic        n_div_in,
  input  wire logic        r_div_in,
  input  wire logic        phase_cmp_valid,
  input  wire logic        phase_in_window,
  output logic             digital_lock_indicator,
  output logic             test_lock_pin_o,
  output logic             test_lock_pin_oe,
  output logic             readback_pin_o,
  output logic             readback_pin_oe,
  output logic             general_output_pin_a_o,
  output logic             general_output_pin_a_oe,
  output logic             general_output_pin_a_pd,
  output logic             general_output_pin_b_o,
  output logic             general_output_pin_b_oe,
  output logic             general_output_pin_b_pd,
  output logic             sync_request,
  output logic             clk_outputs_force_low,
  output logic [3:0]       filter_cap_c4_select,
  output logic [3:0]       filter_cap_c3_select,
  output logic [2:0]       filter_res_r4_select,
  output logic [2:0]       filter_res_r3_select,
  output logic             reference_doubler_enable,
  output logic [1:0]       charge_pump_current_select,
  output logic [11:0]      charge_pump_current_ua
);

  logic [31:0]      lock_pin_and_sync_config_ff;
  logic [31:0]      readback_and_gpo_a_config_ff;
  logic [31:0]      gpo_b_config_ff;
  logic [31:0]      fixed_pattern_register_ff;
  logic [31:0]      loop_filter_component_select_ff;
  logic [31:0]      ref_pump_lockcount_config_ff;
  logic             register_write_protect_ff;
  logic             wr_ok;
  logic [4:0]       lock_pin_source_select;
  logic [2:0]       lock_pin_drive_type;
  logic [2:0]       readback_drive_type;
  logic             hold_sync_until_lock;
  logic [2:0]       gpo_a_code;
  logic [2:0]       gpo_b_code;
  logic [CNT_W-1:0] lock_detect_cycle_count;
  logic [CNT_W-1:0] dld_cnt_ff;
  logic             dld_ff;
  logic             n_prev_ff;
  logic             r_prev_ff;
  logic             n_half_ff;
  logic             r_half_ff;
  logic             nxt_src;
  logic [1:0]       lock_drv;
  logic [1:0]       rb_drv;
  logic [2:0]       gpo_a_drv;
  logic [2:0]       gpo_b_drv;
  logic             sync_ff;
  logic             force_low_ff;

  // Field extraction
  assign lock_pin_source_select  = lock_pin_and_sync_config_ff[pscr_pkg::LOCK_SRC_LSB +: 5];
  assign lock_pin_drive_type     = lock_pin_and_sync_config_ff[pscr_pkg::LOCK_TYPE_LSB +: 3];
  assign hold_sync_until_lock    = lock_pin_and_sync_config_ff[pscr_pkg::HOLD_SYNC_BIT];
  assign readback_drive_type     = readback_and_gpo_a_config_ff[pscr_pkg::RB_TYPE_LSB +: 3];
  assign gpo_a_code              = readback_and_gpo_a_config_ff[pscr_pkg::GPO_A_LSB +: 3];
  assign gpo_b_code              = gpo_b_config_ff[pscr_pkg::GPO_B_LSB +: 3];
  assign lock_detect_cycle_count = ref_pump_lockcount_config_ff[pscr_pkg::DLD_CNT_LSB +: CNT_W];

  // Pin drive: {out, oe} for a source value under a drive type
  function automatic logic [1:0] pin_drive(input logic [2:0] typ, input logic val);
    case (typ)
      pscr_pkg::DRV_PUSH_PULL: pin_drive = {val, 1'b1};
      pscr_pkg::DRV_INVERTED:  pin_drive = {~val, 1'b1};
      pscr_pkg::DRV_OPEN_SRC:  pin_drive = {1'b0, ~val};
      pscr_pkg::DRV_OPEN_DRN:  pin_drive = {1'b1, val};
      default:                 pin_drive = 2'b00;
    endcase
  endfunction

  // General output: {out, oe, pull-down}
  function automatic logic [2:0] gpo_drive(input logic [2:0] code);
    case (code)
      pscr_pkg::GPO_PULL_DOWN: gpo_drive = 3'b001;
      pscr_pkg::GPO_LOW:       gpo_drive = 3'b010;
      pscr_pkg::GPO_HIGH:      gpo_drive = 3'b110;
      default:                 gpo_drive = 3'b000;
    endcase
  endfunction

  // Write gate: protected range refused while write protect is set
  assign wr_ok = wr_en & (~register_write_protect_ff | (wr_addr > pscr_pkg::ADDR_LAST_PROT));

  // Register writes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lock_pin_and_sync_config_ff     <= pscr_pkg::RST_LOCK_PIN;
      readback_and_gpo_a_config_ff    <= pscr_pkg::RST_READBACK;
      gpo_b_config_ff                 <= pscr_pkg::RST_GPO_B;
      fixed_pattern_register_ff       <= pscr_pkg::RST_FIXED;
      loop_filter_component_select_ff <= pscr_pkg::RST_FILTER;
      ref_pump_lockcount_config_ff    <= pscr_pkg::RST_REF_PUMP;
      register_write_protect_ff       <= pscr_pkg::RST_PROTECT;
    end else if (wr_ok) begin
      case (wr_addr)
        pscr_pkg::ADDR_LOCK_PIN: lock_pin_and_sync_config_ff     <= wr_data;
        pscr_pkg::ADDR_READBACK: readback_and_gpo_a_config_ff    <= wr_data;
        pscr_pkg::ADDR_GPO_B:    gpo_b_config_ff                 <= wr_data;
        pscr_pkg::ADDR_FIXED:    fixed_pattern_register_ff       <= wr_data;
        pscr_pkg::ADDR_FILTER:   loop_filter_component_select_ff <= wr_data;
        pscr_pkg::ADDR_REF_PUMP: ref_pump_lockcount_config_ff    <= wr_data;
        pscr_pkg::ADDR_PROTECT:  register_write_protect_ff <= wr_data[pscr_pkg::PROTECT_BIT];
        default: ;
      endcase
    end
  end

  // Readback word, unmapped indices read zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_data <= 32'h00000000;
    end else begin
      case (rd_addr)
        pscr_pkg::ADDR_LOCK_PIN: rd_data <= lock_pin_and_sync_config_ff;
        pscr_pkg::ADDR_READBACK: rd_data <= readback_and_gpo_a_config_ff;
        pscr_pkg::ADDR_GPO_B:    rd_data <= gpo_b_config_ff;
        pscr_pkg::ADDR_FIXED:    rd_data <= fixed_pattern_register_ff;
        pscr_pkg::ADDR_FILTER:   rd_data <= loop_filter_component_select_ff;
        pscr_pkg::ADDR_REF_PUMP: rd_data <= ref_pump_lockcount_config_ff;
        pscr_pkg::ADDR_PROTECT:  rd_data <= {26'h000000, register_write_protect_ff,
                                             pscr_pkg::ADDR_PROTECT};
        default:                 rd_data <= 32'h00000000;
      endcase
    end
  end

  // Digital lock detect counter
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dld_cnt_ff <= '0;
      dld_ff     <= 1'b0;
    end else if (phase_cmp_valid) begin
      if (!phase_in_window) begin
        dld_cnt_ff <= '0;
        dld_ff     <= 1'b0;
      end else if (dld_cnt_ff < lock_detect_cycle_count) begin
        dld_cnt_ff <= dld_cnt_ff + 1'b1;
        dld_ff     <= (dld_cnt_ff + 1'b1) >= lock_detect_cycle_count;
      end
    end
  end
  assign digital_lock_indicator = dld_ff;

  // Half-rate copies of the divider outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      n_prev_ff <= n_div_in; // Track the pin so release shows no false edge
      r_prev_ff <= r_div_in; // Track the pin so release shows no false edge
      n_half_ff <= 1'b0;
      r_half_ff <= 1'b0;
    end else begin
      n_prev_ff <= n_div_in;
      r_prev_ff <= r_div_in;
      n_half_ff <= n_half_ff ^ (n_div_in & ~n_prev_ff);
      r_half_ff <= r_half_ff ^ (r_div_in & ~r_prev_ff);
    end
  end

  // Lock pin source select
  always_comb begin
    case (lock_pin_source_select)
      pscr_pkg::SRC_DLD:    nxt_src = dld_ff;
      pscr_pkg::SRC_N:      nxt_src = n_div_in;
      pscr_pkg::SRC_N_HALF: nxt_src = n_half_ff;
      pscr_pkg::SRC_R:      nxt_src = r_div_in;
      pscr_pkg::SRC_R_HALF: nxt_src = r_half_ff;
      default:              nxt_src = 1'b0;
    endcase
  end

  assign lock_drv  = pin_drive(lock_pin_drive_type, nxt_src);
  assign rb_drv    = pin_drive(readback_drive_type, readback_bit);
  assign gpo_a_drv = gpo_drive(gpo_a_code);
  assign gpo_b_drv = gpo_drive(gpo_b_code);

  // Pin flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      test_lock_pin_o         <= 1'b0;
      test_lock_pin_oe        <= 1'b0;
      readback_pin_o          <= 1'b0;
      readback_pin_oe         <= 1'b0;
      general_output_pin_a_o  <= 1'b0;
      general_output_pin_a_oe <= 1'b0;
      general_output_pin_a_pd <= 1'b0;
      general_output_pin_b_o  <= 1'b0;
      general_output_pin_b_oe <= 1'b0;
      general_output_pin_b_pd <= 1'b0;
    end else begin
      {test_lock_pin_o, test_lock_pin_oe} <= lock_drv;
      {readback_pin_o, readback_pin_oe}   <= rb_drv;
      {general_output_pin_a_o, general_output_pin_a_oe, general_output_pin_a_pd} <= gpo_a_drv;
      {general_output_pin_b_o, general_output_pin_b_oe, general_output_pin_b_pd} <= gpo_b_drv;
    end
  end

  // Sync request held until lock, and clock output forcing
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync_ff      <= 1'b0;
      force_low_ff <= 1'b0;
    end else begin
      sync_ff      <= hold_sync_until_lock & ~dld_ff;
      force_low_ff <= hold_sync_until_lock & ~dld_ff;
    end
  end
  assign sync_request          = sync_ff;
  assign clk_outputs_force_low = force_low_ff;

  // Static analog selections
  assign filter_cap_c4_select = loop_filter_component_select_ff[pscr_pkg::CAP_C4_LSB +: 4];
  assign filter_cap_c3_select = loop_filter_component_select_ff[pscr_pkg::CAP_C3_LSB +: 4];
  assign filter_res_r4_select = loop_filter_component_select_ff[pscr_pkg::RES_R4_LSB +: 3];
  assign filter_res_r3_select = loop_filter_component_select_ff[pscr_pkg::RES_R3_LSB +: 3];
  assign reference_doubler_enable =
    ref_pump_lockcount_config_ff[pscr_pkg::DOUBLER_BIT];
  assign charge_pump_current_select = ref_pump_lockcount_config_ff[pscr_pkg::PUMP_LSB +: 2];

  // Pump current in microamps
  always_comb begin
    case (charge_pump_current_select)
      2'h0:    charge_pump_current_ua = 12'h064;
      2'h1:    charge_pump_current_ua = 12'h190;
      2'h2:    charge_pump_current_ua = 12'h640;
      default: charge_pump_current_ua = 12'hC80;
    endcase
  end

  // Checks
  sequence s_in_window;
    phase_cmp_valid && phase_in_window;
  endsequence

  property p_src_dld;
    @(posedge core_clk) disable iff (!rst_b)
      (lock_pin_source_select == pscr_pkg::SRC_DLD && lock_pin_drive_type == pscr_pkg::DRV_PUSH_PULL)
      |=> (test_lock_pin_o == $past(dld_ff)) && test_lock_pin_oe;
  endproperty
  a_src_dld: assert property (p_src_dld) else $error("lock pin not showing lock");

  property p_inv_low;
    @(posedge core_clk) disable iff (!rst_b)
      (lock_pin_source_select == pscr_pkg::SRC_LOW && lock_pin_drive_type == pscr_pkg::DRV_INVERTED)
      |=> test_lock_pin_o && test_lock_pin_oe;
  endproperty
  a_inv_low: assert property (p_inv_low) else $error("inverted low not high");

  property p_reserved_type;
    @(posedge core_clk) disable iff (!rst_b)
      (lock_pin_drive_type < pscr_pkg::DRV_PUSH_PULL) |=> !test_lock_pin_oe;
  endproperty
  a_reserved_type: assert property (p_reserved_type) else $error("reserved type drives");

  property p_sync_hold;
    @(posedge core_clk) disable iff (!rst_b)
      (hold_sync_until_lock && !dld_ff) |=> sync_request && clk_outputs_force_low;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync not held");

  property p_sync_off;
    @(posedge core_clk) disable iff (!rst_b)
      (!hold_sync_until_lock || dld_ff) |=> !sync_request && !clk_outputs_force_low;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync forced wrongly");

  property p_gpo_a_high;
    @(posedge core_clk) disable iff (!rst_b)
      (gpo_a_code == pscr_pkg::GPO_HIGH)
      |=> general_output_pin_a_o && general_output_pin_a_oe && !general_output_pin_a_pd;
  endproperty
  a_gpo_a_high: assert property (p_gpo_a_high) else $error("output A not high");

  property p_gpo_b_pd;
    @(posedge core_clk) disable iff (!rst_b)
      (gpo_b_code == pscr_pkg::GPO_PULL_DOWN)
      |=> !general_output_pin_b_oe && general_output_pin_b_pd;
  endproperty
  a_gpo_b_pd: assert property (p_gpo_b_pd) else $error("output B not pulled down");

  property p_protect;
    @(posedge core_clk) disable iff (!rst_b)
      (register_write_protect_ff && wr_en && wr_addr == pscr_pkg::ADDR_LOCK_PIN)
      |=> $stable(lock_pin_and_sync_config_ff);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write accepted");

  property p_drop;
    @(posedge core_clk) disable iff (!rst_b)
      (phase_cmp_valid && !phase_in_window) |=> !dld_ff && dld_cnt_ff == '0;
  endproperty
  a_drop: assert property (p_drop) else $error("lock kept after miss");

  property p_count_one;
    @(posedge core_clk) disable iff (!rst_b)
      (lock_detect_cycle_count == 1 && dld_cnt_ff == '0) ##0 s_in_window |=> dld_ff;
  endproperty
  a_count_one: assert property (p_count_one) else $error("lock late for count one");

  property p_no_early;
    @(posedge core_clk) disable iff (!rst_b)
      $rose(dld_ff) |-> dld_cnt_ff >= lock_detect_cycle_count;
  endproperty
  a_no_early: assert property (p_no_early) else $error("lock before count");

endmodule

//--- verif/pscr_host.sv
// Host controller model driving the register bank's write and readback ports
`timescale 1ns/1ps
module pscr_host (
  input  wire logic        core_clk,
  input  wire logic [31:0] rd_data,
  output logic             wr_en,
  output logic      [4:0]  wr_addr,
  output logic      [31:0] wr_data,
  output logic      [4:0]  rd_addr
);
  // Idle bus at time zero
  initial begin
    wr_en   = 1'b0;
    wr_addr = 5'h00;
    wr_data = 32'h00000000;
    rd_addr = 5'h00;
  end

  // One-cycle strobe, launched and dropped at falling edges
  task automatic write_reg(input logic [4:0] a, input logic [31:0] d);
    @(negedge core_clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_en   = 1'b0;
    wr_data = ~d; // Released bus shows no stale word
  endtask

  // Word comes back one edge after the index is presented
  task automatic read_reg(input logic [4:0] a, output logic [31:0] d);
    @(negedge core_clk);
    rd_addr = a;
    @(negedge core_clk);
    d = rd_data;
  endtask

  // Start-up programming of the fixed-pattern register
  task automatic init_fixed();
    write_reg(pscr_pkg::ADDR_FIXED, pscr_pkg::RST_FIXED);
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the PLL pin and configuration register bank
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, rst_b, wr_en, readback_bit, n_div_in, r_div_in;
  logic        phase_cmp_valid, phase_in_window, lock, lp_o, lp_oe, rb_o, rb_oe;
  logic        ga_o, ga_oe, ga_pd, gb_o, gb_oe, gb_pd, sync_req, force_low, dbl;
  logic [4:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data, v;
  logic [3:0]  c4, c3;
  logic [2:0]  r4, r3;
  logic [1:0]  pump_sel, e;
  logic [11:0] pump_ua;
  logic [4:0]  srcs [4] = '{pscr_pkg::SRC_LOW, pscr_pkg::SRC_DLD, pscr_pkg::SRC_N, pscr_pkg::SRC_R};
  logic [2:0]  ks [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  logic [11:0] uas [4] = '{12'h064, 12'h190, 12'h640, 12'hC80};
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // Clock of 40 ns period
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  pscr_host host (.core_clk(core_clk), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr));

  pscr_regs #(.CNT_W(14)) dut (.core_clk(core_clk), .rst_b(rst_b), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .readback_bit(readback_bit), .n_div_in(n_div_in), .r_div_in(r_div_in),
    .phase_cmp_valid(phase_cmp_valid), .phase_in_window(phase_in_window),
    .digital_lock_indicator(lock), .test_lock_pin_o(lp_o), .test_lock_pin_oe(lp_oe),
    .readback_pin_o(rb_o), .readback_pin_oe(rb_oe), .general_output_pin_a_o(ga_o),
    .general_output_pin_a_oe(ga_oe), .general_output_pin_a_pd(ga_pd),
    .general_output_pin_b_o(gb_o), .general_output_pin_b_oe(gb_oe),
    .general_output_pin_b_pd(gb_pd), .sync_request(sync_req),
    .clk_outputs_force_low(force_low), .filter_cap_c4_select(c4),
    .filter_cap_c3_select(c3), .filter_res_r4_select(r4), .filter_res_r3_select(r3),
    .reference_doubler_enable(dbl), .charge_pump_current_select(pump_sel),
    .charge_pump_current_ua(pump_ua));

  // Word builders for the lock pin and reference/pump registers
  function automatic logic [31:0] lpw(logic [4:0] s, logic [2:0] t, logic h);
    return {s, t, h, 18'h00000, 5'h0C};
  endfunction
  function automatic logic [31:0] rpw(logic d, logic [1:0] p, logic [13:0] c);
    return {2'h0, d, 1'h0, p, 6'h00, c, 6'h1A};
  endfunction

  // Comparison with count and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    host.read_reg(a, v);
    chk("rd_data", exp, v);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // One phase comparison pulse
  task automatic cmp(input logic w);
    @(negedge core_clk);
    phase_cmp_valid = 1'b1;
    phase_in_window = w;
    @(negedge core_clk);
    phase_cmp_valid = 1'b0;
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    readback_bit = 1'b1;
    n_div_in = 1'b1;
    r_div_in = 1'b0;
    phase_cmp_valid = 1'b0;
    phase_in_window = 1'b0;
    idle(3);
    rst_b = 1'b1;
    rd_chk(pscr_pkg::ADDR_LOCK_PIN, pscr_pkg::RST_LOCK_PIN);
    rd_chk(pscr_pkg::ADDR_READBACK, pscr_pkg::RST_READBACK);
    rd_chk(pscr_pkg::ADDR_GPO_B, pscr_pkg::RST_GPO_B);
    rd_chk(pscr_pkg::ADDR_FILTER, pscr_pkg::RST_FILTER);
    rd_chk(pscr_pkg::ADDR_REF_PUMP, pscr_pkg::RST_REF_PUMP);
    rd_chk(5'h0F, 32'h00000000);
    host.init_fixed();
    rd_chk(pscr_pkg::ADDR_FIXED, pscr_pkg::RST_FIXED);
    // Sources through every drive type; lock is low here
    for (int i = 0; i < 4; i++) begin
      for (int t = 3; t < 7; t++) begin
        host.write_reg(pscr_pkg::ADDR_LOCK_PIN, lpw(srcs[i], t[2:0], 1'b0));
        idle(3);
        e[1] = (i == 2);
        e = (t == 3) ? {e[1], 1'b1} : (t == 4) ? {~e[1], 1'b1} :
            (t == 5) ? {1'b0, ~e[1]} : {1'b1, e[1]};
        chk("lock pin", {30'h0, e}, {30'h0, lp_o, lp_oe});
      end
    end
    host.write_reg(pscr_pkg::ADDR_LOCK_PIN, lpw(pscr_pkg::SRC_N, 3'h0, 1'b0));
    idle(3);
    chk("lock pin oe", 32'h0, {31'h0, lp_oe});
    // Half-rate sources toggle on a rising divider edge
    host.write_reg(pscr_pkg::ADDR_LOCK_PIN,
                   lpw(pscr_pkg::SRC_N_HALF, pscr_pkg::DRV_PUSH_PULL, 1'b0));
    idle(3);
    chk("n half before", 32'h0, {31'h0, lp_o});
    n_div_in = 1'b0;
    idle(1);
    n_div_in = 1'b1;
    idle(3);
    chk("n half after", 32'h1, {31'h0, lp_o});
    host.write_reg(pscr_pkg::ADDR_LOCK_PIN,
                   lpw(pscr_pkg::SRC_R_HALF, pscr_pkg::DRV_PUSH_PULL, 1'b0));
    idle(3);
    chk("r half before", 32'h0, {31'h0, lp_o});
    r_div_in = 1'b1;
    idle(3);
    chk("r half after", 32'h1, {31'h0, lp_o});
    // General outputs and readback pin over reserved and defined codes
    foreach (ks[k]) begin
      host.write_reg(pscr_pkg::ADDR_READBACK, {5'h00, ks[k], 5'h00, ks[k], 11'h000, 5'h0D});
      host.write_reg(pscr_pkg::ADDR_GPO_B, {5'h00, ks[k], 19'h00000, 5'h0E});
      idle(3);
      v = {29'h0, ks[k] == 3'h2, ks[k] > 3'h2, ks[k] == 3'h4};
      chk("gpo a", v, {29'h0, ga_pd, ga_oe, ga_o & ga_oe});
      chk("gpo b", v, {29'h0, gb_pd, gb_oe, gb_o & gb_oe});
      chk("readback pin", {30'h0, ks[k] == 3'h3, ks[k] > 3'h2},
          {30'h0, rb_o & rb_oe, rb_oe});
    end
    // Filter fields at distinct codes, then write protection
    host.write_reg(pscr_pkg::ADDR_FILTER, 32'hDC430018);
    host.write_reg(pscr_pkg::ADDR_PROTECT, 32'h0000003F);
    host.write_reg(pscr_pkg::ADDR_FILTER, 32'h12300018);
    host.write_reg(pscr_pkg::ADDR_LOCK_PIN,
                   lpw(pscr_pkg::SRC_LOW, pscr_pkg::DRV_INVERTED, 1'b1));
    idle(2);
    chk("filter", 32'h0000DC43,
        {16'h0, c4, c3, 1'b0, r4, 1'b0, r3});
    rd_chk(pscr_pkg::ADDR_FILTER, 32'hDC430018);
    rd_chk(pscr_pkg::ADDR_LOCK_PIN,
           lpw(pscr_pkg::SRC_R_HALF, pscr_pkg::DRV_PUSH_PULL, 1'b0));
    rd_chk(pscr_pkg::ADDR_PROTECT, 32'h0000003F);
    host.write_reg(pscr_pkg::ADDR_PROTECT, 32'h0000001F);
    host.write_reg(pscr_pkg::ADDR_FILTER, 32'h12300018);
    rd_chk(pscr_pkg::ADDR_FILTER, 32'h12300018);
    // Pump current codes and doubler
    for (int p = 0; p < 4; p++) begin
      host.write_reg(pscr_pkg::ADDR_REF_PUMP, rpw(p[0], p[1:0], 14'h0001));
      idle(3);
      chk("pump", {17'h0, p[0], p[1:0], uas[p]}, {17'h0, dbl, pump_sel, pump_ua});
    end
    // Lock count of three, held sync, loss and reacquire
    host.write_reg(pscr_pkg::ADDR_REF_PUMP, rpw(1'b0, 2'h0, 14'h0003));
    host.write_reg(pscr_pkg::ADDR_LOCK_PIN, lpw(pscr_pkg::SRC_DLD, pscr_pkg::DRV_PUSH_PULL, 1'b1));
    idle(3);
    chk("sync", 32'h3, {28'h0, lock, lp_o, sync_req, force_low});
    cmp(1'b1);
    cmp(1'b1);
    idle(3);
    chk("lock", 32'h3, {28'h0, lock, lp_o, sync_req, force_low});
    cmp(1'b1);
    idle(3);
    chk("lock", 32'hC, {28'h0, lock, lp_o, sync_req, force_low});
    cmp(1'b0);
    idle(3);
    chk("lock", 32'h3, {28'h0, lock, lp_o, sync_req, force_low});
    cmp(1'b1);
    cmp(1'b1);
    idle(3);
    chk("lock", 32'h3, {28'h0, lock, lp_o, sync_req, force_low});
    cmp(1'b1);
    idle(3);
    chk("lock", 32'hC, {28'h0, lock, lp_o, sync_req, force_low});
    // Count of one locks on the first in-window comparison
    host.write_reg(pscr_pkg::ADDR_REF_PUMP, rpw(1'b0, 2'h0, 14'h0001));
    cmp(1'b0);
    idle(3);
    chk("lock", 32'h3, {28'h0, lock, lp_o, sync_req, force_low});
    cmp(1'b1);
    idle(3);
    chk("lock", 32'hC, {28'h0, lock, lp_o, sync_req, force_low});
    print_verdict();
  end
endmodule
